// >>> hw/msc_pkg.sv
/*
 Package for the MAC statistics counter bank: register offsets, counter
 widths, control bit positions, frame length limits and bus carriers.
 Assumes a 32-bit Avalon-MM slave with word addressing in bytes.
*/
package msc_pkg;

   // ****************************************************************
   // Register map (byte addresses)
   // ****************************************************************
   localparam int MSC_NUM_CNT = 18;
   localparam logic [7:0] MSC_OFS_CTRL = 8'h00;
   localparam logic [7:0] MSC_OFS_CNT_BASE = 8'h10;
   localparam logic [7:0] MSC_OFS_LAST = 8'h54;

   // Counter indices, one per statistics register
   localparam int MSC_SCOL = 0;
   localparam int MSC_MCOL = 1;
   localparam int MSC_GOOD = 2;
   localparam int MSC_CRC = 3;
   localparam int MSC_ALGN = 4;
   localparam int MSC_DEFR = 5;
   localparam int MSC_LATE_COLLISION_COUNT = 6;
   localparam int MSC_XCOL = 7;
   localparam int MSC_TX_UNDERRUN_COUNT = 8;
   localparam int MSC_CSER = 9;
   localparam int MSC_RRES = 10;
   localparam int MSC_RX_OVERRUN_COUNT = 11;
   localparam int MSC_RSYM = 12;
   localparam int MSC_XLEN = 13;
   localparam int MSC_JABR = 14;
   localparam int MSC_USIZ = 15;
   localparam int MSC_SQE = 16;
   localparam int MSC_LMIS = 17;

   // Counter widths in the same order
   localparam int MSC_WIDTHS [MSC_NUM_CNT] = '{16, 16, 24, 8, 8, 16, 8, 8, 8,
                                              8, 16, 8, 8, 8, 8, 8, 8, 8};

   // ****************************************************************
   // Control register fields
   // ****************************************************************
   localparam int MSC_BIT_RXEN = 2;
   localparam int MSC_BIT_WREN = 7;
   localparam int MSC_BIT_BIGFRM = 8;
   localparam int MSC_BIT_HALFDUP = 9;
   localparam int MSC_BIT_LENCHK = 16;
   localparam logic [31:0] MSC_CTRL_RESET = 32'h0000_0000;
   localparam logic [31:0] MSC_CTRL_MASK = 32'h0001_0384;

   // ****************************************************************
   // Frame limits and timing
   // ****************************************************************
   localparam logic [15:0] MSC_MIN_LEN = 16'h0040;
   localparam logic [15:0] MSC_MAX_LEN = 16'h05EE;
   localparam logic [15:0] MSC_MAX_BIG_LEN = 16'h0600;
   localparam logic [15:0] MSC_TYPE_MIN = 16'h0600;
   localparam int MSC_SQE_BITS = 96;

   // ****************************************************************
   // Carriers
   // ****************************************************************
   typedef struct packed {
      logic done;          // One-cycle end of a transmit attempt
      logic underrun;
      logic [4:0] collisions;  // 0..16
      logic lateCol;
      logic deferred;
      logic carrierErr;
   } msc_tx_evt_t;

   typedef struct packed {
      logic done;          // One-cycle end of a received frame
      logic [15:0] length;
      logic oddBits;
      logic crcErr;
      logic symbolErr;
      logic addrMatch;
      logic stored;
      logic noBuffer;
      logic overrun;
      logic [15:0] lenType;
   } msc_rx_evt_t;

   typedef struct packed {
      logic [7:0] address;
      logic read;
      logic write;
      logic [31:0] writedata;
   } msc_bus_req_t;

endpackage : msc_pkg

// >>> hw/msc_sat_counter.sv
/*
 One saturating statistics counter of parameterised width.
 Assumes inc, clr and load arrive as single-cycle strobes on sys_clk.
*/
`timescale 1ns/1ps
`default_nettype none
module msc_sat_counter import msc_pkg::*; #(
   parameter int WIDTH = 8
) (
   input wire logic sys_clk,
   input wire logic rst,
   input wire logic inc,
   input wire logic clr,
   input wire logic load,
   input wire logic [31:0] loadValue,
   output logic [WIDTH-1:0] count
);

   typedef struct packed {
      logic [WIDTH-1:0] cnt;
   } msc_cnt_state_t;

   msc_cnt_state_t state_q, state_d;

   // Next value: load, clear on read, saturating increment
   always_comb begin
      state_d = state_q;
      if (load) begin
         state_d.cnt = loadValue[WIDTH-1:0];
      end else if (clr) begin
         state_d.cnt = inc ? {{(WIDTH-1){1'b0}}, 1'b1} : '0;
      end else if (inc && state_q.cnt != {WIDTH{1'b1}}) begin
         state_d.cnt = state_q.cnt + {{(WIDTH-1){1'b0}}, 1'b1};
      end
   end

   // Register the counter
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         state_q <= '0;
      end else begin
         state_q <= state_d;
      end
   end

   assign count = state_q.cnt;

endmodule : msc_sat_counter
`default_nettype wire

// >>> hw/msc_sqe_timer.sv
/*
 SQE test watchdog: after tx_en falls, waits 96 bit times for col.
 Assumes bitTick is a one-cycle pulse per bit time and col is synchronised.
*/
`timescale 1ns/1ps
`default_nettype none
module msc_sqe_timer import msc_pkg::*; (
   input wire logic sys_clk,
   input wire logic rst,
   input wire logic enable,
   input wire logic bitTick,
   input wire logic txEn,
   input wire logic col,
   output logic sqeFail
);

   typedef enum logic [1:0] {IDLE, SENDING, WAITING} msc_sqe_st_t;

   typedef struct packed {
      msc_sqe_st_t st;
      logic [6:0] bits;
      logic fail;
   } msc_sqe_state_t;

   msc_sqe_state_t state_q, state_d;

   // Window after the end of transmission
   always_comb begin
      state_d = state_q;
      state_d.fail = 1'b0;
      case (state_q.st)
         IDLE: begin
            if (txEn && enable) begin
               state_d.st = SENDING;
            end
         end
         SENDING: begin
            if (!txEn) begin
               state_d.st = WAITING;
               state_d.bits = '0;
            end
         end
         WAITING: begin
            if (col) begin
               state_d.st = IDLE;
            end else if (bitTick) begin
               if (state_q.bits == 7'(MSC_SQE_BITS - 1)) begin
                  state_d.fail = 1'b1;
                  state_d.st = IDLE;
               end else begin
                  state_d.bits = state_q.bits + 7'h01;
               end
            end
         end
         default: begin
            state_d.st = IDLE;
         end
      endcase
   end

   // Register the watchdog
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         state_q <= '{st: IDLE, bits: 7'h00, fail: 1'b0};
      end else begin
         state_q <= state_d;
      end
   end

   assign sqeFail = state_q.fail;

endmodule : msc_sqe_timer
`default_nettype wire

// >>> hw/msc_stat_counters.sv
/*
 Statistics counter bank of a 10/100 MAC with an Avalon-MM slave.
 Assumes transmit and receive engines give one-cycle summary pulses on
 sys_clk, and that PHY pins tx_en and col arrive asynchronously.
*/
// Implementation choices: the Avalon-MM register port and the register addresses.
// Behaviour
// - Count frames sent after exactly one collision
// - Count frames sent after two to fifteen collisions
// - Count good, matched, fully stored receive frames
// - Good means legal length, no errors
// - Count whole-byte valid-length CRC or symbol errors
// - Count odd-bit valid-length CRC or symbol errors
// - Count first-attempt deferrals without collision or underrun
// - Count late collisions, also counted as collision
// - Count frames abandoned after sixteen collisions
// - Underrun frames bump only the underrun counter
// - Count half-duplex carrier sense errors only
// - Count matched frames dropped for no buffer
// - Count matched frames lost to receive overrun
// - Count frames received with a symbol error
// - Count error-free oversize frames
// - Count oversize frames with errors as jabbers
// - Count error-free frames shorter than minimum
// - Count missing col within 96 bits after tx_en
// - Count short-versus-length-field frames when enabled
// - Skip type values and oversize in mismatch check
// - Clear on read and saturate at ones
// - Receive counters move only when receive enabled
// - Counter writes need the write-enable bit
`timescale 1ns/1ps
`default_nettype none
module msc_stat_counters import msc_pkg::*; (
   input wire logic sys_clk,
   input wire logic rst,
   // Avalon-MM slave
   input wire logic [7:0] avs_address,
   input wire logic avs_read,
   input wire logic avs_write,
   input wire logic [31:0] avs_writedata,
   output logic [31:0] avs_readdata,
   output logic avs_waitrequest,
   // Engine events
   input wire msc_tx_evt_t txEvt,
   input wire msc_rx_evt_t rxEvt,
   // PHY pins for the SQE test
   input wire logic phyTxEn,
   input wire logic phyCol,
   // Bit-time enable from the MAC clock divider
   input wire logic bitTick
);

   // ****************************************************************
   // State
   // ****************************************************************
   typedef struct packed {
      logic [31:0] ctrl;
      logic [31:0] rdata;
      logic ack;
      logic [1:0] txEnSync;
      logic [1:0] colSync;
   } msc_state_t;

   msc_state_t state_q, state_d;
   logic [MSC_NUM_CNT-1:0] incVec;
   logic [MSC_NUM_CNT-1:0] clrVec;
   logic [MSC_NUM_CNT-1:0] loadVec;
   logic [31:0] cntVal [MSC_NUM_CNT];
   logic sqeFail;
   logic sel;
   logic [4:0] idx;
   logic [5:0] slotDec;
   logic [15:0] maxLen;
   logic badFcs;
   logic lenValid;
   logic tooLong;
   logic tooShort;
   logic rxOn;
   logic txClean;

   // Decode an address into a counter index and a hit flag
   function automatic logic [5:0] msc_decode(input logic [7:0] addr);
      logic [7:0] rel;
      rel = addr - MSC_OFS_CNT_BASE;
      if (addr[1:0] == 2'b00 && addr >= MSC_OFS_CNT_BASE && addr <= MSC_OFS_LAST) begin
         msc_decode = {1'b1, rel[6:2]};
      end else begin
         msc_decode = 6'h00;
      end
   endfunction : msc_decode

   // ****************************************************************
   // Bus decode
   // ****************************************************************
   // Counter slot addressed by the current request
   always_comb begin
      slotDec = msc_decode(avs_address);
      sel = slotDec[5];
      idx = slotDec[4:0];
   end

   // Answer one cycle after the request is seen
   assign avs_waitrequest = (avs_read || avs_write) && !state_q.ack;
   assign avs_readdata = state_q.rdata;

   // ****************************************************************
   // Frame classification
   // ****************************************************************
   // Length limits and error summary
   always_comb begin
      maxLen = state_q.ctrl[MSC_BIT_BIGFRM] ? MSC_MAX_BIG_LEN : MSC_MAX_LEN;
      badFcs = rxEvt.crcErr || rxEvt.symbolErr;
      lenValid = rxEvt.length >= MSC_MIN_LEN && rxEvt.length <= maxLen;
      tooLong = rxEvt.length > maxLen;
      tooShort = rxEvt.length < MSC_MIN_LEN;
      rxOn = rxEvt.done && state_q.ctrl[MSC_BIT_RXEN];
      txClean = txEvt.done && !txEvt.underrun;
   end

   // One increment strobe per counter per frame
   always_comb begin
      incVec = '0;
      incVec[MSC_SCOL] = txClean && txEvt.collisions == 5'h01;
      incVec[MSC_MCOL] = txClean && txEvt.collisions >= 5'h02 && txEvt.collisions <= 5'h0F;
      incVec[MSC_GOOD] = rxOn && rxEvt.addrMatch && rxEvt.stored && lenValid && !badFcs;
      incVec[MSC_CRC] = rxOn && lenValid && !rxEvt.oddBits && badFcs;
      incVec[MSC_ALGN] = rxOn && lenValid && rxEvt.oddBits && badFcs;
      incVec[MSC_DEFR] = txClean && txEvt.deferred && txEvt.collisions == 5'h00;
      incVec[MSC_LATE_COLLISION_COUNT] = txClean && txEvt.lateCol;
      incVec[MSC_XCOL] = txClean && txEvt.collisions == 5'h10;
      incVec[MSC_TX_UNDERRUN_COUNT] = txEvt.done && txEvt.underrun;
      incVec[MSC_CSER] = txClean && txEvt.carrierErr && txEvt.collisions == 5'h00
                         && state_q.ctrl[MSC_BIT_HALFDUP];
      incVec[MSC_RRES] = rxOn && rxEvt.addrMatch && rxEvt.noBuffer;
      incVec[MSC_RX_OVERRUN_COUNT] = rxOn && rxEvt.addrMatch && rxEvt.overrun;
      incVec[MSC_RSYM] = rxOn && rxEvt.symbolErr;
      incVec[MSC_XLEN] = rxOn && tooLong && !badFcs;
      incVec[MSC_JABR] = rxOn && tooLong && badFcs;
      incVec[MSC_USIZ] = rxOn && tooShort && !badFcs;
      incVec[MSC_SQE] = sqeFail;
      incVec[MSC_LMIS] = rxOn && state_q.ctrl[MSC_BIT_LENCHK] && !tooLong
                         && rxEvt.lenType < MSC_TYPE_MIN && rxEvt.length < rxEvt.lenType;
   end

   // ****************************************************************
   // Counters
   // ****************************************************************
   // Read clears and gated writes load the addressed counter
   always_comb begin
      clrVec = '0;
      loadVec = '0;
      if (sel && !state_q.ack) begin
         clrVec[idx] = avs_read;
         loadVec[idx] = avs_write && state_q.ctrl[MSC_BIT_WREN];
      end
   end

   for (genvar i = 0; i < MSC_NUM_CNT; i++) begin : g_cnt
      logic [MSC_WIDTHS[i]-1:0] value;
      msc_sat_counter #(.WIDTH(MSC_WIDTHS[i])) u_cnt (
         .sys_clk(sys_clk),
         .rst(rst),
         .inc(incVec[i]),
         .clr(clrVec[i]),
         .load(loadVec[i]),
         .loadValue(avs_writedata),
         .count(value)
      );
      assign cntVal[i] = 32'(value);
   end

   msc_sqe_timer u_sqe (
      .sys_clk(sys_clk),
      .rst(rst),
      .enable(state_q.ctrl[MSC_BIT_HALFDUP]),
      .bitTick(bitTick),
      .txEn(state_q.txEnSync[1]),
      .col(state_q.colSync[1]),
      .sqeFail(sqeFail)
   );

   // ****************************************************************
   // Control, read data and synchronisers
   // ****************************************************************
   always_comb begin
      state_d = state_q;
      state_d.txEnSync = {state_q.txEnSync[0], phyTxEn};
      state_d.colSync = {state_q.colSync[0], phyCol};
      state_d.ack = (avs_read || avs_write) && !state_q.ack;
      if ((avs_read || avs_write) && !state_q.ack) begin
         if (avs_write && avs_address == MSC_OFS_CTRL) begin
            state_d.ctrl = avs_writedata & MSC_CTRL_MASK;
         end
         if (avs_read) begin
            if (avs_address == MSC_OFS_CTRL) begin
               state_d.rdata = state_q.ctrl;
            end else if (sel) begin
               state_d.rdata = cntVal[idx];
            end else begin
               state_d.rdata = 32'h0000_0000;  // Unmapped reads as zero
            end
         end
      end
   end

   // Register the bank state
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         state_q <= '{ctrl: MSC_CTRL_RESET, rdata: 32'h0000_0000, ack: 1'b0,
                      txEnSync: 2'b00, colSync: 2'b00};
      end else begin
         state_q <= state_d;
      end
   end

endmodule : msc_stat_counters
`default_nettype wire

// >>> tb/msc_stat_checker.sv
/*
 Port checker for the statistics counter bank.
 Assumes it is bound to msc_stat_counters, one clock domain.
*/
`timescale 1ns/1ps
`default_nettype none
module msc_stat_checker import msc_pkg::*; (
   input wire logic sys_clk,
   input wire logic rst,
   input wire logic [7:0] avs_address,
   input wire logic avs_read,
   input wire logic avs_write,
   input wire logic [31:0] avs_readdata,
   input wire logic avs_waitrequest,
   input wire msc_tx_evt_t txEvt,
   input wire msc_rx_evt_t rxEvt
);
   // ****************************************************************
   // Helpers and properties
   // ****************************************************************
   localparam logic [7:0] SqeAdr = 8'(int'(MSC_OFS_CNT_BASE) + 4 * MSC_SQE);
   logic rdDone;
   logic isCnt;
   logic evNone;
   int cntW;
   // Decode of the current bus cycle
   assign rdDone = avs_read && !avs_waitrequest;
   assign isCnt = avs_address >= MSC_OFS_CNT_BASE && avs_address <= MSC_OFS_LAST;
   assign evNone = !txEvt.done && !rxEvt.done;
   // Width of the addressed counter
   always_comb begin
      cntW = 32;
      if (isCnt) cntW = MSC_WIDTHS[(int'(avs_address) - int'(MSC_OFS_CNT_BASE)) >> 2];
   end
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (rst);
   a_wait_first: assert property ($rose(avs_read || avs_write) |-> avs_waitrequest)
      else $error("no wait state on a new request");
   a_one_wait: assert property ((avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
      else $error("wait state longer than one cycle");
   a_idle_nowait: assert property (!(avs_read || avs_write) |-> !avs_waitrequest)
      else $error("wait state without a request");
   a_unmapped_zero: assert property (rdDone && !isCnt && avs_address != MSC_OFS_CTRL
      |-> avs_readdata == 32'h0)
      else $error("unmapped read not zero");
   a_ctrl_bits: assert property (rdDone && avs_address == MSC_OFS_CTRL
      |-> (avs_readdata & ~MSC_CTRL_MASK) == 32'h0)
      else $error("control read shows unused bits");
   a_cnt_width: assert property (rdDone && isCnt |-> (avs_readdata >> cntW) == 32'h0)
      else $error("counter read wider than its counter");
   a_data_stands: assert property (!avs_read |=> $stable(avs_readdata))
      else $error("read data changed without a read");
   a_read_clears: assert property ((rdDone && isCnt && avs_address != SqeAdr && evNone
      && $past(evNone)) ##1 (!avs_read && !avs_write && evNone) ##1 avs_read
      |=> (avs_address != $past(avs_address, 3) || avs_readdata == 32'h0))
      else $error("counter not cleared by read");
   c_read: cover property (rdDone && isCnt);
   c_write: cover property (avs_write && !avs_waitrequest);
   c_rx_crc: cover property (rxEvt.done && rxEvt.crcErr);
   c_tx_excess: cover property (txEvt.done && txEvt.collisions == 5'h10);
endmodule : msc_stat_checker
`default_nettype wire

// >>> tb/msc_phy_model.sv
/*
 PHY model: answers the end of each transmission with a heartbeat on col while sqeOk is set.
 Assumes bitTick pulses once per bit time on sys_clk.
*/
`timescale 1ns/1ps
`default_nettype none
module msc_phy_model (
   input wire logic sys_clk,
   input wire logic rst,
   input wire logic bitTick,
   input wire logic txEn,
   input wire logic sqeOk,
   output logic col
);
   logic txEnQ;
   logic [3:0] left;
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         txEnQ <= 1'b0;
         left <= 4'h0;
      end else begin
         txEnQ <= txEn;
         if (txEnQ && !txEn && sqeOk) left <= 4'h8;
         else if (bitTick && left != 4'h0) left <= left - 4'h1;
      end
   end
   assign col = left != 4'h0;
endmodule : msc_phy_model
`default_nettype wire

// >>> tb/msc_stat_counters_tb.sv
/*
 Self-checking bench for the statistics counter bank.
 Assumes the checker and PHY model files are compiled before it.
*/
`timescale 1ns/1ps
`default_nettype none
module msc_stat_counters_tb import msc_pkg::*;;
   localparam logic [7:0] CrcAdr = 8'(int'(MSC_OFS_CNT_BASE) + 4 * MSC_CRC);
   localparam logic [7:0] SqeAdr = 8'(int'(MSC_OFS_CNT_BASE) + 4 * MSC_SQE);
   logic sys_clk = 1'b0;
   logic rst = 1'b1;
   logic [7:0] avs_address = 8'h00;
   logic avs_read = 1'b0;
   logic avs_write = 1'b0;
   logic [31:0] avs_writedata = 32'h0;
   logic [31:0] avs_readdata;
   logic avs_waitrequest;
   msc_tx_evt_t txEvt = '0;
   msc_rx_evt_t rxEvt = '0;
   logic phyTxEn = 1'b0;
   logic phyCol;
   logic bitTick = 1'b0;
   logic sqeOk = 1'b1;
   logic [31:0] ctl = 32'h0;
   logic [31:0] rd;
   logic [23:0] expc [MSC_NUM_CNT];
   logic [15:0] lens [6] = '{16'h003F, 16'h0040, 16'h05EE, 16'h05EF, 16'h0600, 16'h0601};
   int err_count = 0;
   int checked = 0;
   int seed = 32'h7EEE4E83;
   // ****************************************************************
   // Clock, instances and tasks
   // ****************************************************************
   always #10 sys_clk = ~sys_clk;
   // Bit time every second cycle
   always @(posedge sys_clk) bitTick <= ~bitTick;
   msc_stat_counters i_dut (.sys_clk(sys_clk), .rst(rst), .avs_address(avs_address),
      .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
      .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .txEvt(txEvt),
      .rxEvt(rxEvt), .phyTxEn(phyTxEn), .phyCol(phyCol), .bitTick(bitTick));
   msc_phy_model i_phy (.sys_clk(sys_clk), .rst(rst), .bitTick(bitTick), .txEn(phyTxEn),
      .sqeOk(sqeOk), .col(phyCol));
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      checked++;
      if (seen !== exp) begin
         err_count++;
         $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
      end
   endtask : chk
   task automatic wrap_up();
      $display("checks %0d errors %0d", checked, err_count);
      if (err_count == 0 && checked > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
   endtask : wrap_up
   task automatic busWr(input logic [7:0] a, input logic [31:0] d);
      @(posedge sys_clk);
      avs_address <= a;
      avs_writedata <= d;
      avs_write <= 1'b1;
      do @(posedge sys_clk); while (avs_waitrequest !== 1'b0);
      avs_write <= 1'b0;
   endtask : busWr
   task automatic busRd(input logic [7:0] a);
      @(posedge sys_clk);
      avs_address <= a;
      avs_read <= 1'b1;
      do @(posedge sys_clk); while (avs_waitrequest !== 1'b0);
      rd = avs_readdata;
      avs_read <= 1'b0;
   endtask : busRd
   function automatic void bump(input logic [17:0] m);
      for (int i = 0; i < MSC_NUM_CNT; i++)
         if (m[i] && expc[i] != (24'hFFFFFF >> (24 - MSC_WIDTHS[i]))) expc[i]++;
   endfunction : bump
   function automatic logic [17:0] rxMask(input msc_rx_evt_t e);
      logic [17:0] m;
      logic err;
      logic big;
      logic ok;
      err = e.crcErr || e.symbolErr;
      big = e.length > (ctl[MSC_BIT_BIGFRM] ? MSC_MAX_BIG_LEN : MSC_MAX_LEN);
      ok = e.length >= MSC_MIN_LEN && !big;
      m = '0;
      m[MSC_GOOD] = ok && !err && e.addrMatch && e.stored;
      m[MSC_CRC] = ok && err && !e.oddBits;
      m[MSC_ALGN] = ok && err && e.oddBits;
      m[MSC_RSYM] = e.symbolErr;
      m[MSC_XLEN] = big && !err;
      m[MSC_JABR] = big && err;
      m[MSC_USIZ] = e.length < MSC_MIN_LEN && !err;
      m[MSC_RRES] = e.addrMatch && e.noBuffer;
      m[MSC_RX_OVERRUN_COUNT] = e.addrMatch && e.overrun;
      m[MSC_LMIS] = ctl[MSC_BIT_LENCHK] && e.lenType < MSC_TYPE_MIN
                    && e.length < e.lenType && !big;
      return ctl[MSC_BIT_RXEN] ? m : 18'h0;
   endfunction : rxMask
   function automatic logic [17:0] txMask(input msc_tx_evt_t e);
      logic [17:0] m;
      m = '0;
      m[MSC_TX_UNDERRUN_COUNT] = e.underrun;
      m[MSC_SCOL] = !e.underrun && e.collisions == 5'h01;
      m[MSC_MCOL] = !e.underrun && e.collisions >= 5'h02 && e.collisions <= 5'h0F;
      m[MSC_XCOL] = !e.underrun && e.collisions == 5'h10;
      m[MSC_LATE_COLLISION_COUNT] = !e.underrun && e.lateCol;
      m[MSC_DEFR] = !e.underrun && e.deferred && e.collisions == 5'h00;
      m[MSC_CSER] = !e.underrun && e.carrierErr && ctl[MSC_BIT_HALFDUP] && e.collisions == 5'h00;
      return m;
   endfunction : txMask
   task automatic rxFrame(input msc_rx_evt_t e);
      e.done = 1'b1;
      @(posedge sys_clk);
      rxEvt <= e;
      bump(rxMask(e));
      @(posedge sys_clk);
      rxEvt.done <= 1'b0;
   endtask : rxFrame
   task automatic txFrame(input msc_tx_evt_t e);
      e.done = 1'b1;
      @(posedge sys_clk);
      txEvt <= e;
      bump(txMask(e));
      @(posedge sys_clk);
      txEvt.done <= 1'b0;
   endtask : txFrame
   task automatic randFrames(input int n);
      msc_rx_evt_t r;
      msc_tx_evt_t t;
      logic [31:0] v;
      repeat (n) begin
         v = $random(seed);
         t = '0;
         t.underrun = v[0] & v[1];
         t.collisions = 5'(v[12:8] % 17);
         t.lateCol = v[2] && t.collisions != 5'h00;
         t.deferred = v[3];
         t.carrierErr = v[4];
         txFrame(t);
         r = '0;
         r.length = (v[15:13] == 3'h0) ? lens[v[22:20] % 6] : {5'h00, v[26:16]};
         r.crcErr = v[5];
         r.symbolErr = v[6] & v[7];
         r.oddBits = v[27] && (r.crcErr || r.symbolErr);
         r.addrMatch = v[28] | v[29];
         r.noBuffer = v[30] & v[8];
         r.overrun = v[31] & v[9];
         r.stored = !r.noBuffer && !r.overrun;
         r.lenType = 16'($random(seed)) & 16'h07FF;
         rxFrame(r);
      end
   endtask : randFrames
   task automatic chkAll();
      for (int i = 0; i < MSC_NUM_CNT; i++) begin
         busRd(8'(int'(MSC_OFS_CNT_BASE) + 4 * i));
         chk(rd, {8'h00, expc[i]});
         expc[i] = '0;
      end
   endtask : chkAll
   // ****************************************************************
   // Main sequence and watchdog
   // ****************************************************************
   initial begin
      msc_rx_evt_t cf;
      foreach (expc[i]) expc[i] = '0;
      cf = '0;
      cf.length = 16'h0064;
      cf.crcErr = 1'b1;
      cf.addrMatch = 1'b1;
      cf.stored = 1'b1;
      repeat (5) @(posedge sys_clk);
      rst <= 1'b0;
      busRd(MSC_OFS_CTRL);
      chk(rd, MSC_CTRL_RESET);
      chkAll();
      busWr(MSC_OFS_CTRL, 32'hFFFFFFFF);
      busRd(MSC_OFS_CTRL);
      chk(rd, MSC_CTRL_MASK);
      busWr(8'h60, 32'h0000005A);
      busRd(8'h60);
      chk(rd, 32'h0);
      // Random traffic under several control settings
      for (int k = 0; k < 6; k++) begin
         ctl = 32'($random(seed)) & 32'h00010304;
         if (k < 2) ctl[MSC_BIT_RXEN] = k[0];
         busWr(MSC_OFS_CTRL, ctl);
         randFrames(40);
         chkAll();
      end
      // Write guard, load and saturation
      ctl = 32'h00000004;
      busWr(MSC_OFS_CTRL, ctl);
      busWr(CrcAdr, 32'h0000005A);
      busRd(CrcAdr);
      chk(rd, 32'h0);
      ctl = 32'h00000084;
      busWr(MSC_OFS_CTRL, ctl);
      busWr(CrcAdr, 32'h0000005A);
      busRd(CrcAdr);
      chk(rd, 32'h0000005A);
      busWr(CrcAdr, 32'h000000FE);
      repeat (2) rxFrame(cf);
      busRd(CrcAdr);
      chk(rd, 32'h000000FF);
      busRd(CrcAdr);
      chk(rd, 32'h0);
      // Event meets a clearing read
      fork
         busRd(CrcAdr);
         rxFrame(cf);
      join
      chk(rd, 32'h0);
      busRd(CrcAdr);
      chk(rd, 32'h00000001);
      expc[MSC_CRC] = '0;
      // Heartbeat missing, then present
      ctl = 32'h00000200;
      busWr(MSC_OFS_CTRL, ctl);
      for (int k = 0; k < 2; k++) begin
         sqeOk <= k[0];
         @(posedge sys_clk);
         phyTxEn <= 1'b1;
         repeat (20) @(posedge sys_clk);
         phyTxEn <= 1'b0;
         repeat (300) @(posedge sys_clk);
         busRd(SqeAdr);
         chk(rd, {31'h0, !k[0]});
      end
      wrap_up();
   end
   // Cut a hang short
   initial begin
      repeat (40000) @(posedge sys_clk);
      err_count++;
      $display("[ERR] %0t watchdog expired", $time);
      wrap_up();
   end
endmodule : msc_stat_counters_tb
bind msc_stat_counters msc_stat_checker i_chk (.sys_clk(sys_clk), .rst(rst),
   .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
   .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .txEvt(txEvt),
   .rxEvt(rxEvt));
`default_nettype wire
